// [psc_pkg.sv]
// Purpose: Shared constants, lookup tables and state types of the supervisor.
// Assumes: One 100 MHz reference clock; all timers count that clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package psc_pkg;
  localparam int PSC_CLK_KHZ = 100_000;
  localparam int PSC_NCH = 7;
  localparam int PSC_NPROC = 3;
  localparam int PSC_NPHASE = 4;
  localparam int PSC_PER_W = 9;
  localparam int PSC_HOLD_W = 28;
  localparam int PSC_TMR_W = 20;
  localparam int PSC_FILT_W = 11;
  localparam int PSC_SS_W = 2;
  localparam int PSC_HOLD_UNIT_MS = 500;
  localparam int PSC_HOLD_UNIT_CYC = PSC_HOLD_UNIT_MS * PSC_CLK_KHZ;
  localparam int PSC_OC_TMR_MS = 10;
  localparam int PSC_OC_TMR_CYC = PSC_OC_TMR_MS * PSC_CLK_KHZ;
  localparam int PSC_RST_DLY_MS = 10;
  localparam int PSC_RST_DLY_CYC = PSC_RST_DLY_MS * PSC_CLK_KHZ;
  localparam int PSC_FILT_US = 20;
  localparam int PSC_FILT_CYC = (PSC_FILT_US * PSC_CLK_KHZ + 999) / 1000;
  localparam int PSC_MAIN_KHZ [8] = '{750, 1000, 1250, 1500, 1750, 2000, 2000, 2000};
  localparam int PSC_AUX_KHZ [4] = '{500, 250, 750, 1000};
  localparam int PSC_HOLD_MULT [4] = '{2, 1, 3, 4};
  localparam logic [2:0] PSC_SELECT_PIN_A_TIED_HIGH = 3'h7;
  localparam logic [1:0] PSC_AUX_DEFAULT = 2'h0;
  localparam logic PSC_BTN_IDLE = 1'h1;
  localparam logic PSC_RSP_SHUTOFF = 1'h0;

  typedef enum logic [1:0] {
    PSC_PWR_OFF = 2'h0,
    PSC_PWR_ON = 2'h1,
    PSC_PWR_HOLD = 2'h2,
    PSC_PWR_SDWAIT = 2'h3
  } psc_pwr_t;

  typedef enum logic [1:0] {
    PSC_CH_RUN = 2'h0,
    PSC_CH_LIMIT = 2'h1,
    PSC_CH_RETRY = 2'h2,
    PSC_CH_DEAD = 2'h3
  } psc_ch_t;

  function automatic logic [PSC_PER_W-1:0] psc_period(input int khz);
    return PSC_PER_W'((PSC_CLK_KHZ + khz / 2) / khz);
  endfunction : psc_period
endpackage : psc_pkg

// [psc_div_if.sv]
// Purpose: Control and phase outputs of one clock divider.
// Assumes: Period is in reference clock cycles.
// Notes: Phase bits are registered inside the divider.
interface psc_div_if import psc_pkg::*; #(
  parameter int W = PSC_PER_W,
  parameter int NPH = 1
);
  logic [W-1:0] period;
  logic run;
  logic [NPH-1:0] phase;
  modport ctrl(output period, output run, input phase);
  modport gen(input period, input run, output phase);
endinterface : psc_div_if

// [psc_ovuv_filter.sv]
// Purpose: Qualify one raw voltage detection.
// Assumes: Raw input synchronous to the clock.
// Notes: Output drops at once when the raw level goes away.
module psc_ovuv_filter import psc_pkg::*; #(
  parameter int FILT_CYCLES = PSC_FILT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_raw,
  output logic o_qual
);
  logic [PSC_FILT_W-1:0] cnt;
  wire logic done = cnt == PSC_FILT_W'(FILT_CYCLES - 1);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
      o_qual <= 1'b0;
    end else if (i_clk_en) begin
      cnt <= !i_raw ? '0 : (done ? cnt : cnt + PSC_FILT_W'(1));
      o_qual <= i_raw & done;
    end
  end

  AST_FILT_DROP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && !i_raw |=> !o_qual) else $error("qualified level kept without raw");
  AST_FILT_HELD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_qual) |-> $past(done) && $past(i_raw)) else $error("qualified too early");
endmodule : psc_ovuv_filter

// [psc_clk_divider.sv]
// Purpose: Divide the reference clock into evenly spread phases.
// Assumes: Period of at least four cycles.
// Notes: Odd periods give a slightly short high half.
module psc_clk_divider import psc_pkg::*; #(
  parameter int W = PSC_PER_W,
  parameter int NPH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  psc_div_if.gen dv
);
  logic [W-1:0] cnt;
  logic [NPH-1:0] ph_q;
  logic [NPH-1:0] next_ph;
  wire logic wrap = cnt >= dv.period - W'(1);

  for (genvar k = 0; k < NPH; k++) begin : g_ph
    wire logic [W+2:0] prod = {3'h0, dv.period} * (W+3)'(k);
    wire logic [W-1:0] ofs = W'(prod / (W+3)'(NPH));
    wire logic [W:0] pos = {1'b0, cnt} + {1'b0, ofs};
    wire logic [W:0] wpos = (pos >= {1'b0, dv.period}) ? pos - {1'b0, dv.period} : pos;
    assign next_ph[k] = dv.run && (wpos < {2'h0, dv.period[W-1:1]});
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
      ph_q <= '0;
    end else if (i_clk_en) begin
      cnt <= (!dv.run || wrap) ? '0 : cnt + W'(1);
      ph_q <= next_ph;
    end
  end
  assign dv.phase = ph_q;

  AST_DIV_WRAP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && dv.run && wrap |=> cnt == '0) else $error("divider did not wrap");
endmodule : psc_clk_divider

// [psc_supervisor_control.sv]
// Purpose: Supervisory logic: switching clocks, power button, processor reset, faults.
// Assumes: All inputs synchronous except the power button; index 0..2 are converters 2..4.
// Notes: Long timers are parameters so a simulation can shorten them.
module psc_supervisor_control import psc_pkg::*; #(
  parameter int HOLD_UNIT_CYCLES = PSC_HOLD_UNIT_CYC,
  parameter int TMR_CYCLES = PSC_OC_TMR_CYC,
  parameter int RST_CYCLES = PSC_RST_DLY_CYC,
  parameter int FILT_CYCLES = PSC_FILT_CYC,
  parameter int NCH = PSC_NCH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [2:0] i_select_pin_a,
  input wire logic [PSC_SS_W-1:0] i_ss_pin,
  input wire logic [1:0] i_aux_select_pin_a_sel,
  input wire logic [1:0] i_hold_time_select,
  input wire logic i_hold_mask,
  input wire logic i_flag_clear,
  input wire logic i_global_off_command,
  input wire logic i_power_button_pin,
  input wire logic [NCH-PSC_NPROC-1:0] i_ss_set_wr,
  input wire logic [PSC_SS_W-1:0] i_ss_set_data,
  input wire logic i_gate_drive_ok,
  input wire logic [NCH-1:0] i_ch_enable,
  input wire logic [NCH-1:0] i_ov_raw,
  input wire logic [NCH-1:0] i_uv_raw,
  input wire logic [NCH-1:0] i_oc_soft,
  input wire logic [NCH-1:0] i_short,
  input wire logic [NCH-1:0] i_overtemp,
  input wire logic [NCH-1:0] i_soft_start_busy,
  input wire logic [NCH-1:0] i_scaling_busy,
  input wire logic [NCH-1:0] i_scaling_done_flag,
  input wire logic [NCH-1:0] i_fault_response_select,
  input wire logic [NCH-1:0] i_ovuv_clear,
  output logic [PSC_NPHASE-1:0] o_main_phase,
  output logic o_aux_clk,
  output logic o_power_on,
  output logic o_shutdown_flag,
  output logic o_cpu_rst_out,
  output logic o_cpu_rst_oe,
  output logic [NCH-1:0] o_ch_on,
  output logic [NCH-1:0] o_oc_limit,
  output logic [NCH-1:0] o_overvoltage_flag,
  output logic [NCH-1:0] o_undervoltage_flag,
  output logic [PSC_SS_W*NCH-1:0] o_soft_start_time
);
  psc_pwr_t pwr_state;
  psc_pwr_t next_pwr_state;
  logic strap_done;
  logic [PSC_PER_W-1:0] main_per;
  logic btn_s1;
  logic btn_s2;
  logic btn_d;
  logic [PSC_HOLD_W-1:0] hold_cnt;
  logic [PSC_TMR_W-1:0] rst_cnt;
  logic next_sd_flag;
  logic [NCH-1:0] ch_run;
  logic [NCH-1:0] ch_limit;
  logic [NCH-1:0] ov_q;
  logic [NCH-1:0] uv_q;

  // Switching clocks
  wire logic [PSC_PER_W-1:0] strap_per = psc_period(PSC_MAIN_KHZ[i_select_pin_a]);
  wire logic [PSC_PER_W-1:0] aux_per = psc_period(PSC_AUX_KHZ[i_aux_select_pin_a_sel]);

  psc_div_if #(.W(PSC_PER_W), .NPH(PSC_NPHASE)) main_div();
  psc_div_if #(.W(PSC_PER_W), .NPH(1)) aux_div();

  assign main_div.period = main_per;
  assign main_div.run = strap_done;
  assign aux_div.period = aux_per;
  assign aux_div.run = strap_done;

  // One reference feeds both dividers, no free-running second source
  psc_clk_divider #(.W(PSC_PER_W), .NPH(PSC_NPHASE)) u_main_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .dv(main_div)
  );

  psc_clk_divider #(.W(PSC_PER_W), .NPH(1)) u_aux_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .dv(aux_div)
  );

  assign o_main_phase = main_div.phase;
  assign o_aux_clk = aux_div.phase[0];

  // Straps other than the aux select are read once, at the first enabled edge after reset release
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_done <= 1'b0;
      main_per <= psc_period(PSC_MAIN_KHZ[PSC_SELECT_PIN_A_TIED_HIGH]);
    end else if (i_clk_en && !strap_done) begin
      strap_done <= 1'b1;
      main_per <= strap_per;
    end
  end

  // Soft-start times
  for (genvar c = 0; c < NCH; c++) begin : g_ss
    if (c < PSC_NPROC) begin : g_pin
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_soft_start_time[c*PSC_SS_W +: PSC_SS_W] <= '0;
        end else if (i_clk_en && !strap_done) begin
          o_soft_start_time[c*PSC_SS_W +: PSC_SS_W] <= i_ss_pin;
        end
      end
    end else begin : g_usr
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_soft_start_time[c*PSC_SS_W +: PSC_SS_W] <= '0;
        end else if (i_clk_en && !strap_done) begin
          o_soft_start_time[c*PSC_SS_W +: PSC_SS_W] <= i_ss_pin;
        end else if (i_clk_en && i_ss_set_wr[c-PSC_NPROC]) begin
          o_soft_start_time[c*PSC_SS_W +: PSC_SS_W] <= i_ss_set_data;
        end
      end
    end
  end

  // Power button: btn_s1 feeds only btn_s2
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      btn_s1 <= PSC_BTN_IDLE;
      btn_s2 <= PSC_BTN_IDLE;
      btn_d <= PSC_BTN_IDLE;
    end else if (i_clk_en) begin
      btn_s1 <= i_power_button_pin;
      btn_s2 <= btn_s1;
      btn_d <= btn_s2;
    end
  end

  wire logic btn_fall = btn_d && !btn_s2;
  wire logic btn_low = !btn_s2;
  wire logic [PSC_HOLD_W-1:0] hold_target =
    PSC_HOLD_W'(HOLD_UNIT_CYCLES * PSC_HOLD_MULT[i_hold_time_select]);
  wire logic hold_done = hold_cnt == hold_target - PSC_HOLD_W'(1);
  wire logic flag_set = (pwr_state == PSC_PWR_HOLD) && btn_low && hold_done
    && !i_global_off_command;

  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      PSC_PWR_OFF: begin
        if (!strap_done || btn_fall) begin
          next_pwr_state = PSC_PWR_ON;
        end
      end
      PSC_PWR_ON: begin
        if (i_global_off_command) begin
          next_pwr_state = PSC_PWR_OFF;
        end else if (btn_low) begin
          next_pwr_state = PSC_PWR_HOLD;
        end
      end
      PSC_PWR_HOLD: begin
        if (i_global_off_command) begin
          next_pwr_state = PSC_PWR_OFF;
        end else if (!btn_low) begin
          next_pwr_state = PSC_PWR_ON;
        end else if (hold_done) begin
          next_pwr_state = PSC_PWR_SDWAIT;
        end
      end
      PSC_PWR_SDWAIT: begin
        // Button level is not looked at here at all
        if (i_global_off_command) begin
          next_pwr_state = PSC_PWR_OFF;
        end else if (i_flag_clear) begin
          next_pwr_state = PSC_PWR_ON;
        end else if (hold_done) begin
          next_pwr_state = i_hold_mask ? PSC_PWR_ON : PSC_PWR_OFF;
        end
      end
      default: begin
        next_pwr_state = PSC_PWR_OFF;
      end
    endcase
  end

  // A new press while the flag is being cleared still sets it
  assign next_sd_flag = flag_set | (o_shutdown_flag & !i_flag_clear);

  wire logic hold_restart = (next_pwr_state != pwr_state);
  wire logic pwr_up = (pwr_state == PSC_PWR_OFF) && (next_pwr_state == PSC_PWR_ON);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_state <= PSC_PWR_OFF;
      hold_cnt <= '0;
      o_shutdown_flag <= 1'b0;
      o_power_on <= 1'b0;
    end else if (i_clk_en) begin
      pwr_state <= next_pwr_state;
      hold_cnt <= hold_restart ? '0 : hold_cnt + PSC_HOLD_W'(1);
      o_shutdown_flag <= next_sd_flag;
      o_power_on <= next_pwr_state != PSC_PWR_OFF;
    end
  end

  // Converter channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam bit IS_PROC = (c < PSC_NPROC);
    psc_ch_t ch_state;
    psc_ch_t next_ch_state;
    logic [PSC_TMR_W-1:0] ch_cnt;
    logic [PSC_TMR_W-1:0] next_ch_cnt;
    logic retry_used;

    psc_ovuv_filter #(.FILT_CYCLES(FILT_CYCLES)) u_ov_filt (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_raw(i_ov_raw[c]),
      .o_qual(ov_q[c])
    );

    psc_ovuv_filter #(.FILT_CYCLES(FILT_CYCLES)) u_uv_filt (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_raw(i_uv_raw[c]),
      .o_qual(uv_q[c])
    );

    wire logic scal_mask = i_scaling_busy[c] && !i_scaling_done_flag[c];
    wire logic ov_set = ov_q[c] && !scal_mask;
    wire logic uv_set = uv_q[c] && !scal_mask;
    wire logic rsp_off = (i_fault_response_select[c] == PSC_RSP_SHUTOFF)
      && (ov_set || uv_set);
    wire logic tmr_done = ch_cnt == PSC_TMR_W'(TMR_CYCLES - 1);
    wire psc_ch_t fail_state = (IS_PROC && !retry_used) ? PSC_CH_RETRY : PSC_CH_DEAD;

    always_comb begin
      next_ch_state = ch_state;
      next_ch_cnt = ch_cnt;
      case (ch_state)
        PSC_CH_RUN: begin
          next_ch_cnt = '0;
          if (i_overtemp[c] || rsp_off) begin
            next_ch_state = PSC_CH_DEAD;
          end else if (i_short[c]) begin
            next_ch_state = fail_state;
          end else if (i_oc_soft[c]) begin
            next_ch_state = PSC_CH_LIMIT;
          end
        end
        PSC_CH_LIMIT: begin
          next_ch_cnt = ch_cnt + PSC_TMR_W'(1);
          if (i_overtemp[c] || rsp_off) begin
            next_ch_state = PSC_CH_DEAD;
          end else if (i_short[c] || tmr_done) begin
            next_ch_state = fail_state;
            next_ch_cnt = '0;
          end else if (!i_oc_soft[c]) begin
            next_ch_state = PSC_CH_RUN;
            next_ch_cnt = '0;
          end
        end
        PSC_CH_RETRY: begin
          next_ch_cnt = ch_cnt + PSC_TMR_W'(1);
          if (tmr_done) begin
            next_ch_state = PSC_CH_RUN;
            next_ch_cnt = '0;
          end
        end
        PSC_CH_DEAD: begin
          next_ch_cnt = '0;
        end
        default: begin
          next_ch_state = PSC_CH_DEAD;
        end
      endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ch_state <= PSC_CH_RUN;
        ch_cnt <= '0;
        retry_used <= 1'b0;
      end else if (i_clk_en) begin
        ch_state <= pwr_up ? PSC_CH_RUN : next_ch_state;
        ch_cnt <= pwr_up ? '0 : next_ch_cnt;
        retry_used <= !pwr_up && (retry_used || next_ch_state == PSC_CH_RETRY);
      end
    end

    assign ch_run[c] = (next_ch_state == PSC_CH_RUN) || (next_ch_state == PSC_CH_LIMIT);
    assign ch_limit[c] = next_ch_state == PSC_CH_LIMIT;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_ch_on[c] <= 1'b0;
        o_oc_limit[c] <= 1'b0;
        o_overvoltage_flag[c] <= 1'b0;
        o_undervoltage_flag[c] <= 1'b0;
      end else if (i_clk_en) begin
        o_ch_on[c] <= (next_pwr_state != PSC_PWR_OFF) && i_ch_enable[c] && ch_run[c];
        o_oc_limit[c] <= ch_limit[c];
        o_overvoltage_flag[c] <= ov_set || (o_overvoltage_flag[c] && !i_ovuv_clear[c]);
        o_undervoltage_flag[c] <= uv_set || (o_undervoltage_flag[c] && !i_ovuv_clear[c]);
      end
    end

    AST_CH_REPORT_ONLY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && ch_state == PSC_CH_RUN && i_fault_response_select[c] && ov_set
      && !i_overtemp[c] && !i_short[c] && !i_oc_soft[c] && !pwr_up
      |=> ch_state == PSC_CH_RUN && o_overvoltage_flag[c])
      else $error("report-only fault changed output state");
    AST_CH_SHORT_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_clk_en && ch_state == PSC_CH_RUN && i_short[c] && !pwr_up
      |=> ch_state == PSC_CH_RETRY || ch_state == PSC_CH_DEAD)
      else $error("short did not turn output off");
  end

  // Processor reset: any processor supply (channels 0..2) not good pulls it low at once
  logic [PSC_NPROC-1:0] in_reg;
  for (genvar k = 0; k < PSC_NPROC; k++) begin : g_inreg
    assign in_reg[k] = o_ch_on[k] && !i_soft_start_busy[k] && !i_overtemp[k];
  end

  // Report-only voltage flags do not enter this term
  wire logic proc_good = i_gate_drive_ok && (&in_reg) && o_power_on;
  wire logic rst_due = rst_cnt == PSC_TMR_W'(RST_CYCLES - 1);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_cnt <= '0;
      o_cpu_rst_oe <= 1'b1;
      o_cpu_rst_out <= 1'b0;
    end else if (i_clk_en) begin
      rst_cnt <= (!proc_good || rst_due) ? '0 : rst_cnt + PSC_TMR_W'(1);
      o_cpu_rst_oe <= !(proc_good && (rst_due || !o_cpu_rst_oe));
      o_cpu_rst_out <= 1'b0;
    end
  end

  AST_BTN_START: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && pwr_state == PSC_PWR_OFF && btn_fall |=> pwr_state == PSC_PWR_ON)
    else $error("falling edge did not start the device");
  AST_RELEASE_IGNORED: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && pwr_state == PSC_PWR_SDWAIT && !btn_low && !hold_done
    && !i_flag_clear && !i_global_off_command |=> pwr_state == PSC_PWR_SDWAIT)
    else $error("button release disturbed the countdown");
  AST_GLOBAL_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && pwr_state != PSC_PWR_OFF && i_global_off_command
    |=> pwr_state == PSC_PWR_OFF ##1 o_cpu_rst_oe)
    else $error("global off not honoured");
  AST_ABORT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && pwr_state == PSC_PWR_SDWAIT && i_flag_clear && !i_global_off_command
    |=> pwr_state == PSC_PWR_ON && !o_shutdown_flag)
    else $error("flag clear did not abort shutdown");
  AST_MASK_KEEPS_ON: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && pwr_state == PSC_PWR_SDWAIT && hold_done && i_hold_mask
    && !i_global_off_command |=> o_power_on)
    else $error("masked hold sequence powered off");
  AST_SD_EXPIRE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && pwr_state == PSC_PWR_SDWAIT && hold_done && !i_hold_mask
    && !i_flag_clear |=> !o_power_on)
    else $error("second interval expiry did not power off");
  AST_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && flag_set |=> o_shutdown_flag && pwr_state == PSC_PWR_SDWAIT && hold_cnt == '0)
    else $error("shutdown flag not set at hold expiry");
  AST_RST_DELAY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(o_cpu_rst_oe) |-> $past(rst_due) && $past(proc_good))
    else $error("reset released without full delay");
  AST_RST_ASSERT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && !proc_good |=> o_cpu_rst_oe)
    else $error("reset not driven low on bad supply");
  AST_DEFAULT_SELECT_PIN_A: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en && !strap_done && i_select_pin_a == PSC_SELECT_PIN_A_TIED_HIGH
    |=> main_per == psc_period(PSC_MAIN_KHZ[PSC_SELECT_PIN_A_TIED_HIGH]))
    else $error("tied-high select did not give top frequency");
endmodule : psc_supervisor_control

// [psc_host_model.sv]
// Purpose: Host processor model: shutdown flag clear, global off, channel enables.
// Assumes: Requests arrive by non-blocking assignment at the falling edge.
// Notes: A host still held in reset issues no command.
module psc_host_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_oe,
  input wire logic [1:0] i_req,
  output logic o_flag_clear,
  output logic o_global_off,
  output logic [6:0] o_ch_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Processor group never disabled by the host
  assign o_ch_enable = 7'h7f;
  initial begin
    o_flag_clear = 1'h0;
    o_global_off = 1'h0;
  end
  // One-cycle pulses; a processor in reset cannot talk
  always @(negedge i_ref_clk) begin
    o_flag_clear <= i_req == 2'h1 && !i_rst_oe;
    o_global_off <= i_req == 2'h2 && !i_rst_oe;
  end
endmodule : psc_host_model

// [testbench.sv]
// Purpose: Self-checking bench of the supervisor control block.
// Assumes: Shortened timers: hold unit 20, timer 10, reset delay 8, filter 4.
// Notes: All stimulus changes at the falling edge.
module testbench import psc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, ce = 1, btn = 1, gd = 1, hm = 0, fc, go, pon, sdf, rst_oe, rout;
  logic [1:0] req = 0, ssd = 0, hsel = 2'h1;
  logic [3:0] ssw = 0, mph;
  logic aux;
  logic [6:0] ovr = 0, shrt = 0, frs = 0, ovc = 0, z = 0, en, con, ovf;
  logic [6:0] uvr = 0, scb = 0, ocs = 0, ssb = 0, unf, ocl;
  logic [13:0] sst;
  logic [2:0] st;
  int n_mismatch = 0, tests_run = 0, k;
  assign st = {rst_oe, sdf, pon};
  always #5 clk = ~clk;
  psc_host_model psc_host_model_i (.i_ref_clk(clk), .i_rst_oe(rst_oe), .i_req(req),
      .o_flag_clear(fc), .o_global_off(go), .o_ch_enable(en));
  psc_supervisor_control #(.HOLD_UNIT_CYCLES(20), .TMR_CYCLES(10), .RST_CYCLES(8),
      .FILT_CYCLES(4)) psc_supervisor_control_i (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_clk_en(ce), .i_select_pin_a(3'h7), .i_ss_pin(2'h2), .i_aux_select_pin_a_sel(2'h0),
      .i_hold_time_select(hsel), .i_hold_mask(hm), .i_flag_clear(fc),
      .i_global_off_command(go), .i_power_button_pin(btn), .i_ss_set_wr(ssw),
      .i_ss_set_data(ssd), .i_gate_drive_ok(gd), .i_ch_enable(en), .i_ov_raw(ovr),
      .i_uv_raw(uvr), .i_oc_soft(ocs), .i_short(shrt), .i_overtemp(7'h00),
      .i_soft_start_busy(ssb), .i_scaling_busy(scb), .i_scaling_done_flag(z),
      .i_fault_response_select(frs), .i_ovuv_clear(ovc), .o_main_phase(mph),
      .o_aux_clk(aux), .o_power_on(pon), .o_shutdown_flag(sdf), .o_cpu_rst_out(rout),
      .o_cpu_rst_oe(rst_oe), .o_ch_on(con), .o_oc_limit(ocl), .o_overvoltage_flag(ovf),
      .o_undervoltage_flag(unf), .o_soft_start_time(sst));
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // Bounded wait on one status bit; k holds the cycles spent
  task automatic await(input int sel, input logic v, input int lim);
    for (k = 0; k < lim && st[sel] !== v; k++) @(negedge clk);
    if (st[sel] !== v) begin
      n_mismatch++;
      $display("unexpected status_%0d expected %b seen %b", sel, v, st[sel]);
      give_verdict();
    end
  endtask : await
  // Freeze under clock enable, then one window of clock counts
  task automatic clocks();
    int nh = 0, nr = 0, na = 0, nx = 0;
    logic [4:0] cur, prev;
    ce <= 0;
    @(negedge clk);
    prev = {aux, mph};
    repeat (13) @(negedge clk);
    check("freeze", {aux, mph}, prev);
    ce <= 1;
    repeat (200) begin
      @(negedge clk);
      cur = {aux, mph};
      nh += cur[0];
      nr += cur[0] && !prev[0];
      na += cur[4];
      nx += (cur[0] == cur[2]) + (cur[1] == cur[3]);
      prev = cur;
    end
    check("main_high", nh, 100);
    check("main_rises", nr, 4);
    check("aux_high", na, 100);
    check("phase_spread", nx, 0);
  endtask : clocks
  task automatic host(input logic [1:0] r);
    req <= r;
    @(negedge clk);
    req <= 2'h0;
    repeat (2) @(negedge clk);
  endtask : host
  initial begin
    repeat (10) @(negedge clk);
    check("rst_pin", {rout, rst_oe}, 2'b01);
    rst_n <= 1;
    await(0, 1, 20);
    await(2, 0, 40);
    check("rst_delay", k >= 7 && k <= 10, 1);
    check("ss_strap", sst, {7{2'h2}});
    ssw <= 4'h1;
    ssd <= 2'h3;
    @(negedge clk);
    ssw <= 4'h0;
    @(negedge clk);
    check("ss_write", sst, {{3{2'h2}}, 2'h3, {3{2'h2}}});
    clocks();
    $display("done power up");
    frs <= 7'h05;
    ovr <= 7'h03;
    uvr <= 7'h04;
    scb <= 7'h04;
    repeat (3) @(negedge clk);
    ovr <= 7'h01;
    repeat (4) @(negedge clk);
    check("ov_report", {ovf[1:0], con[1:0], rst_oe}, 5'b01110);
    check("uv_masked", unf[2], 1'b0);
    scb <= 7'h00;
    ovr <= 7'h00;
    uvr <= 7'h00;
    @(negedge clk);
    check("uv_unmasked", {unf[2], con[2], rst_oe}, 3'b110);
    ovc <= 7'h05;
    @(negedge clk);
    ovc <= 7'h00;
    check("ovuv_clear", {ovf[0], unf[2]}, 2'b00);
    $display("done voltage faults");
    btn <= 0;
    await(1, 1, 80);
    check("hold", k >= 20 && k <= 26, 1);
    btn <= 1;
    host(2'h1);
    check("abort", st, 3'b001);
    hm <= 1;
    btn <= 0;
    await(1, 1, 80);
    btn <= 1;
    repeat (30) @(negedge clk);
    check("mask", st, 3'b011);
    hm <= 0;
    host(2'h1);
    hsel <= 2'h0;
    btn <= 0;
    await(1, 1, 80);
    btn <= 1;
    await(0, 0, 60);
    check("sd_wait", k >= 39 && k <= 42, 1);
    repeat (2) @(negedge clk);
    check("off_rst", st[2], 1);
    btn <= 0;
    await(0, 1, 10);
    btn <= 1;
    check("button_on", k <= 7, 1);
    ssb <= 7'h01;
    repeat (15) @(negedge clk);
    check("ss_busy", rst_oe, 1'b1);
    ssb <= 7'h00;
    await(2, 0, 40);
    $display("done button");
    ocs <= 7'h10;
    repeat (3) @(negedge clk);
    check("oc_limit", {ocl[4], con[4]}, 2'b11);
    ocs <= 7'h00;
    @(negedge clk);
    check("oc_resume", {ocl[4], con[4]}, 2'b01);
    ocs <= 7'h10;
    repeat (10) @(negedge clk);
    check("oc_hold", {ocl[4], con[4], rst_oe}, 3'b110);
    @(negedge clk);
    check("oc_expire", {ocl[4], con[4]}, 2'b00);
    ocs <= 7'h00;
    shrt <= 7'h08;
    repeat (3) @(negedge clk);
    check("short_aux", {con[3], rst_oe}, 2'b00);
    shrt <= 7'h02;
    await(2, 1, 5);
    shrt <= 7'h00;
    check("short_cut", con[1], 0);
    await(2, 0, 40);
    check("retry", k >= 15, 1);
    gd <= 0;
    repeat (2) @(negedge clk);
    check("gate_drop", rst_oe, 1'b1);
    gd <= 1;
    await(2, 0, 40);
    host(2'h2);
    check("global_off", {st[2], st[0]}, 2'b10);
    $display("done faults and global off");
    give_verdict();
  end
endmodule : testbench
